// >>> src/fcs_crc_byte.sv
//------------------------------------------------------------
// CRC byte step
//------------------------------------------------------------
// Purpose: One CCITT CRC update over a byte, MSB first
// Assumes: Purely combinational
// Notes:   Chained twice per flash word by the scanner
`timescale 1ns/100ps
module fcs_crc_byte
   import fcs_pkg::*;
(
   input  wire logic [15:0] crcIn,   // Running checksum
   input  wire logic [7:0]  dataIn,  // Byte to fold in
   output logic      [15:0] crcOut   // Updated checksum
);

   // Shift the byte in bit by bit
   always_comb begin
      logic [15:0] c;
      c = crcIn;
      for (int i = 7; i >= 0; i--) begin
         if (c[15] ^ dataIn[i]) begin
            c = {c[14:0], 1'b0} ^ CRC_POLY;
         end else begin
            c = {c[14:0], 1'b0};
         end
      end
      crcOut = c;
   end

endmodule

// >>> src/fcs_pkg.sv
//------------------------------------------------------------
// Package
//------------------------------------------------------------
// Purpose: Shared constants and types of the flash CRC scanner
// Assumes: Single peripheral clock domain
// Notes:   Bit positions refer to the write data ports
package fcs_pkg;

   // CRC constants
   localparam logic [15:0] CRC_INIT     = 16'hFFFF;
   localparam logic [15:0] CRC_POLY     = 16'h1021;

   // Timing in peripheral clock cycles
   localparam int          START_DELAY  = 3;
   localparam int          FETCH_PERIOD = 3;
   localparam logic [1:0]  START_LOAD   = 2'(START_DELAY - 2);
   localparam logic [1:0]  FETCH_LAST   = 2'(FETCH_PERIOD - 1);

   // Control write data bit positions
   localparam int          CTRL_ENABLE  = 0;
   localparam int          CTRL_NMI_TRIGGER_ENABLE   = 1;
   localparam int          CTRL_RESET   = 2;

   // Status write data bit positions
   localparam int          STAT_BUSY    = 0;
   localparam int          STAT_OK      = 1;

   // Section select codes
   localparam logic [1:0]  SRC_FLASH    = 2'h0;
   localparam logic [1:0]  SRC_APPBOOT  = 2'h1;
   localparam logic [1:0]  SRC_BOOT     = 2'h2;

   // Access mode codes
   localparam logic [1:0]  MODE_RUN     = 2'h0;
   localparam logic [1:0]  MODE_INIT    = 2'h1;

   // Reset values
   localparam logic [1:0]  MODE_RST     = 2'h0;
   localparam logic [1:0]  SRC_RST      = 2'h0;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_START,
      ST_SCAN
   } fcs_state_t;

endpackage

// >>> src/fcs_scanner.sv
//------------------------------------------------------------
// Scanner top
//------------------------------------------------------------
// Purpose: Flash CRC scanner with debugger and reset-init hooks
// Assumes: Flash word valid the cycle after the registered read
// Notes:   Section end inputs are byte addresses of the last byte
`timescale 1ns/100ps
module fcs_scanner
   import fcs_pkg::*;
#(
   parameter int AW = 16
)(
   input  wire logic          clk,          // Peripheral clock
   input  wire logic          rst_b,        // System reset, sync
   input  wire logic          clkEn,        // Freezes state when low
   input  wire logic          ctrlWrCpu,    // CPU control write
   input  wire logic          ctrlWrDbg,    // Debugger control write
   input  wire logic [2:0]    ctrlWdata,    // Reset, nmi en, enable
   input  wire logic          cfgWrCpu,     // CPU config write
   input  wire logic          cfgWrDbg,     // Debugger config write
   input  wire logic [3:0]    cfgWdata,     // Mode[3:2], src[1:0]
   input  wire logic          statWrDbg,    // Debugger status write
   input  wire logic [1:0]    statWdata,    // Ok, busy
   input  wire logic          dbgAccess,    // Debugger access pulse
   input  wire logic          dbgRelease,   // Internal reg or detach
   input  wire logic          dbgMirrorRd,  // Mirror status read
   input  wire logic          cpuSleep,     // CPU in any sleep mode
   input  wire logic          initPhase,    // Reset init running
   input  wire logic          initScanEn,   // User config: init scan
   input  wire logic [1:0]    initSrc,      // User config: section
   input  wire logic [AW-1:0] bootLast,     // Last boot byte
   input  wire logic [AW-1:0] appLast,      // Last application byte
   input  wire logic [AW-1:0] flashLast,    // Last flash byte
   input  wire logic [15:0]   flashData,    // Fetched word
   output logic               flashRd,      // Word fetch strobe
   output logic      [AW-1:0] flashAddr,    // Word byte address
   output logic               cpuStall,     // Priority access stall
   output logic               enableOut,    // Enable bit
   output logic               nmiEnOut,     // NMI trigger enable
   output logic      [1:0]    modeOut,      // Access mode
   output logic      [1:0]    srcOut,       // Section select
   output logic               busyOut,      // Busy flag
   output logic               okOut,        // Pass flag
   output logic               nmiReq,       // Non-maskable interrupt
   output logic               dbgBusy,      // Mirrored busy
   output logic               dbgOk,        // Mirrored pass flag
   output logic               cpuInitHold   // Hold CPU in init
);

   typedef struct packed {
      fcs_state_t    st;
      logic          enable;
      logic          nmi_trigger_enable;
      logic [1:0]    mode;
      logic [1:0]    src;
      logic          busy;
      logic          ok;
      logic          nmi;
      logic          hold;
      logic [1:0]    startCnt;
      logic [1:0]    fetchCnt;
      logic          flashRd;
      logic          rdPend;
      logic [AW-1:0] addr;
      logic [15:0]   crc;
      logic          stall;
      logic          dbgBusy;
      logic          dbgOk;
      logic          initDone;
      logic          initHold;
   } fcs_regs_t;

   fcs_regs_t q_q;
   fcs_regs_t q_d;

   logic          ctrlWr;
   logic          cfgWr;
   logic          startAcc;
   logic          doReset;
   logic          go;
   logic          done;
   logic [15:0]   crcLo;
   logic [15:0]   crcHi;
   logic [AW-1:0] lastByte;

   //------------------------------------------------------------
   // CRC datapath
   //------------------------------------------------------------
   // Low byte first: it is the lower address
   fcs_crc_byte u_crcLo (
      .crcIn  (q_q.crc),
      .dataIn (flashData[7:0]),
      .crcOut (crcLo)
   );

   fcs_crc_byte u_crcHi (
      .crcIn  (crcLo),
      .dataIn (flashData[15:8]),
      .crcOut (crcHi)
   );

   //------------------------------------------------------------
   // Decode
   //------------------------------------------------------------
   // Section end and write qualifiers
   always_comb begin
      unique case (q_q.src)
         SRC_FLASH:   lastByte = flashLast;
         SRC_APPBOOT: lastByte = appLast;
         default:     lastByte = bootLast;
      endcase
      ctrlWr   = (ctrlWrCpu | ctrlWrDbg) & ~q_q.nmi;
      cfgWr    = (cfgWrCpu | cfgWrDbg) & ~q_q.nmi;
      doReset  = ctrlWr & ctrlWdata[CTRL_RESET] & (~q_q.nmi_trigger_enable | ~q_q.busy);
      startAcc = ctrlWr & ctrlWdata[CTRL_ENABLE] & ~doReset;
      go       = ~cpuSleep & ~q_q.hold;
      done     = q_q.rdPend & (q_q.st == ST_SCAN)
               & ({q_q.addr[AW-1:1], 1'b1} == lastByte);
   end

   //------------------------------------------------------------
   // Next state
   //------------------------------------------------------------
   always_comb begin
      q_d         = q_q;
      q_d.flashRd = 1'b0;
      q_d.rdPend  = q_q.flashRd;
      // Word consumed one cycle after fetch
      if (q_q.rdPend && q_q.st == ST_SCAN) begin
         q_d.crc  = crcHi;
         q_d.addr = q_q.addr + AW'(2);
         if (done) begin
            q_d.st   = ST_IDLE;
            q_d.busy = 1'b0;
            q_d.ok   = (crcHi == 16'h0000);
            if (crcHi != 16'h0000 && q_q.nmi_trigger_enable) begin
               q_d.nmi = 1'b1;
            end
            if (crcHi == 16'h0000) begin
               q_d.initHold = 1'b0;
            end
         end
      end
      // Start countdown and fetch cadence
      if (q_q.st == ST_START && go) begin
         if (q_q.startCnt == 2'h0) begin
            q_d.st = ST_SCAN;
         end else begin
            q_d.startCnt = q_q.startCnt - 2'h1;
         end
      end
      if (q_q.st == ST_SCAN && go && !done) begin
         q_d.fetchCnt = (q_q.fetchCnt == FETCH_LAST) ? 2'h0
                      : q_q.fetchCnt + 2'h1;
         if (q_q.fetchCnt == 2'h0) begin
            q_d.flashRd = 1'b1;
         end
      end
      // Debugger hold and release
      if (dbgAccess) begin
         q_d.hold = 1'b1;
      end else if ((dbgRelease || dbgMirrorRd) && q_q.hold) begin
         q_d.hold = 1'b0;
         if (q_q.busy && q_q.st == ST_SCAN) begin
            q_d.st       = ST_START;
            q_d.startCnt = START_LOAD;
            q_d.fetchCnt = 2'h0;
            q_d.addr     = '0;
            q_d.crc      = CRC_INIT;
            q_d.flashRd  = 1'b0;
         end
      end
      // Control and config writes
      if (ctrlWr) begin
         q_d.enable = ctrlWdata[CTRL_ENABLE];
         if (!q_q.busy && ctrlWdata[CTRL_NMI_TRIGGER_ENABLE]) begin
            q_d.nmi_trigger_enable = 1'b1;
         end
      end
      if (cfgWr && !q_q.busy) begin
         q_d.mode = cfgWdata[3:2];
         q_d.src  = cfgWdata[1:0];
      end
      // Debugger status write
      if (statWrDbg && !q_q.nmi) begin
         if (!statWdata[STAT_OK]) begin
            q_d.ok = 1'b0;
            if (q_q.nmi_trigger_enable) begin
               q_d.nmi = 1'b1;
            end
         end else begin
            q_d.ok = 1'b1;
         end
         if (statWdata[STAT_BUSY]) begin
            q_d.busy     = 1'b1;
            q_d.st       = ST_START;
            q_d.startCnt = START_LOAD;
            q_d.fetchCnt = 2'h0;
            q_d.addr     = '0;
            q_d.crc      = CRC_INIT;
            q_d.flashRd  = 1'b0;
         end else begin
            q_d.busy    = 1'b0;
            q_d.st      = ST_IDLE;
            q_d.flashRd = 1'b0;
         end
      end
      // Enable or reset-init start
      if (startAcc || (initPhase && initScanEn && !q_q.initDone
                       && !q_q.nmi)) begin
         if (!startAcc) begin
            q_d.enable   = 1'b1;
            q_d.mode     = MODE_INIT;
            q_d.src      = initSrc;
            q_d.initDone = 1'b1;
            q_d.initHold = 1'b1;
         end
         q_d.busy     = 1'b1;
         q_d.st       = ST_START;
         q_d.startCnt = START_LOAD;
         q_d.fetchCnt = 2'h0;
         q_d.addr     = '0;
         q_d.crc      = CRC_INIT;
         q_d.flashRd  = 1'b0;
      end
      // Reset strobe clears enable, mode, section, busy, pass flag and state
      if (doReset) begin
         q_d.enable  = 1'b0;
         q_d.mode    = MODE_RST;
         q_d.src     = SRC_RST;
         q_d.busy    = 1'b0;
         q_d.ok      = 1'b0;
         q_d.st      = ST_IDLE;
         q_d.flashRd = 1'b0;
      end
      if (initPhase && initScanEn && !q_q.initDone) begin
         q_d.initDone = 1'b1;
      end
      q_d.nmi     = q_d.nmi | q_q.nmi;
      q_d.stall   = q_d.busy & (q_d.st == ST_SCAN);
      q_d.dbgBusy = q_q.busy;
      q_d.dbgOk   = q_q.ok;
   end

   //------------------------------------------------------------
   // State register
   //------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         q_q          <= '0;
         q_q.st       <= ST_IDLE;
         q_q.mode     <= MODE_RST;
         q_q.src      <= SRC_RST;
         q_q.crc      <= CRC_INIT;
      end else if (clkEn) begin
         q_q <= q_d;
      end
   end

   // Outputs straight from flops
   assign flashRd     = q_q.flashRd;
   assign flashAddr   = q_q.addr;
   assign cpuStall    = q_q.stall;
   assign enableOut   = q_q.enable;
   assign nmiEnOut    = q_q.nmi_trigger_enable;
   assign modeOut     = q_q.mode;
   assign srcOut      = q_q.src;
   assign busyOut     = q_q.busy;
   assign okOut       = q_q.ok;
   assign nmiReq      = q_q.nmi;
   assign dbgBusy     = q_q.dbgBusy;
   assign dbgOk       = q_q.dbgOk;
   assign cpuInitHold = q_q.initHold;

   //------------------------------------------------------------
   // Assertions
   //------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   property p_nmiSticky;
      q_q.nmi |=> q_q.nmi;
   endproperty
   a_nmiSticky: assert property (p_nmiSticky)
      else $error("NMI request dropped");

   property p_startPreset;
      (clkEn && startAcc) |=> (q_q.st == ST_START
         && q_q.crc == 16'hFFFF && q_q.addr == '0);
   endproperty
   a_startPreset: assert property (p_startPreset)
      else $error("Scan start without preset");

   property p_startDelay;
      (clkEn && startAcc && !statWrDbg && !dbgAccess)
      ##1 (clkEn && go && !ctrlWr && !statWrDbg && !dbgAccess)[*2]
      |=> q_q.st == ST_SCAN;
   endproperty
   a_startDelay: assert property (p_startDelay)
      else $error("Scan not begun three cycles after enable");

   property p_fetchSpacing;
      q_q.flashRd |=> !q_q.flashRd ##1 !q_q.flashRd;
   endproperty
   a_fetchSpacing: assert property (p_fetchSpacing)
      else $error("Fetches closer than three cycles");

   property p_sleepPause;
      (clkEn && cpuSleep) |=> !q_q.flashRd;
   endproperty
   a_sleepPause: assert property (p_sleepPause)
      else $error("Fetch issued during sleep");

   property p_holdBusy;
      (clkEn && q_q.hold && q_q.busy && !statWrDbg && !doReset && !done
       && !(ctrlWr && ctrlWdata[CTRL_ENABLE]))
      |=> q_q.busy && !q_q.flashRd;
   endproperty
   a_holdBusy: assert property (p_holdBusy)
      else $error("Held scan lost busy or fetched");

   property p_cfgLocked;
      (q_q.busy && !doReset) |=> $stable({q_q.mode, q_q.src});
   endproperty
   a_cfgLocked: assert property (p_cfgLocked)
      else $error("Config changed while busy");

   property p_writesBlocked;
      q_q.nmi |=> $stable({q_q.enable, q_q.nmi_trigger_enable, q_q.mode, q_q.src});
   endproperty
   a_writesBlocked: assert property (p_writesBlocked)
      else $error("Register changed after NMI");

   property p_passResult;
      (clkEn && done && !statWrDbg && !doReset && !startAcc)
      |=> !q_q.busy && (q_q.ok == ($past(crcHi) == 16'h0000));
   endproperty
   a_passResult: assert property (p_passResult)
      else $error("Wrong result at section end");

   property p_failNmi;
      (clkEn && done && crcHi != 16'h0000 && q_q.nmi_trigger_enable) |=> q_q.nmi;
   endproperty
   a_failNmi: assert property (p_failNmi)
      else $error("CRC failure did not raise NMI");

   property p_okWriteNmi;
      (clkEn && statWrDbg && !statWdata[STAT_OK] && q_q.nmi_trigger_enable && !q_q.nmi)
      |=> q_q.nmi && !q_q.ok;
   endproperty
   a_okWriteNmi: assert property (p_okWriteNmi)
      else $error("Clearing pass flag did not raise NMI");

   property p_busyAbort;
      (clkEn && statWrDbg && !q_q.nmi && !statWdata[STAT_BUSY]
       && !startAcc && !(initPhase && initScanEn && !q_q.initDone))
      |=> !q_q.busy ##1 !q_q.flashRd;
   endproperty
   a_busyAbort: assert property (p_busyAbort)
      else $error("Scan continued after busy cleared");

   c_pass:    cover property (done ##1 q_q.ok);
   c_failNmi: cover property (done ##1 q_q.nmi);
   c_restart: cover property (q_q.hold && q_q.busy ##1 dbgRelease
                              ##1 q_q.st == ST_START);
   c_init:    cover property (initPhase ##1 q_q.initHold);

endmodule

// >>> testbench/fcs_flash_model.sv
//------------------------------------------------------------
// Flash model
//------------------------------------------------------------
// Purpose: Program memory seen by the scanner's fetch port
// Assumes: One word answered the cycle after each fetch strobe
// Notes:   Contents loaded by the bench before each scan
`timescale 1ns/100ps
module fcs_flash_model #(
   parameter int AW = 16
)(
   input  wire logic          clk,        // Peripheral clock
   input  wire logic          flashRd,    // Word fetch strobe
   input  wire logic [AW-1:0] flashAddr,  // Even byte address
   output logic      [15:0]   flashData   // Fetched word
);
   logic [7:0] mem [0:63];                // Byte array

   initial flashData = 16'h0000;

   // Low byte from even address; toggles when not read so that
   // a late or early sample never sees a stale word
   always @(posedge clk) begin
      if (flashRd === 1'b1) begin
         flashData <= {mem[{flashAddr[5:1], 1'b1}],
                       mem[{flashAddr[5:1], 1'b0}]};
      end else begin
         flashData <= ~flashData;
      end
   end
endmodule

// >>> testbench/test_flash_crc_scanner.sv
//------------------------------------------------------------
// Scanner bench
//------------------------------------------------------------
// Purpose: Self-checking bench of the flash CRC scanner
// Assumes: 64-byte flash, boot ends at 15, application at 31
// Notes:   Inputs change 1 ns after the rising edge
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module test_flash_crc_scanner;
   import fcs_pkg::*;
   localparam int LIMIT = 20000;
   typedef struct packed {
      logic [1:0] src;
      logic [7:0] bad;
      logic       expOk;
   } fcs_row_t;
   logic clk, rst_b, clkEn, ctrlWrCpu, ctrlWrDbg, cfgWrCpu, cfgWrDbg;
   logic statWrDbg, dbgAccess, dbgRelease, dbgMirrorRd, cpuSleep;
   logic initPhase, initScanEn, flashRd, cpuStall, enableOut, nmiEnOut;
   logic busyOut, okOut, nmiReq, dbgBusy, dbgOk, cpuInitHold;
   logic [2:0]  ctrlWdata;
   logic [3:0]  cfgWdata;
   logic [1:0]  statWdata, initSrc, modeOut, srcOut;
   logic [15:0] bootLast, appLast, flashLast, flashData, flashAddr;
   int          err_total, checks, fetches, cyc, n;
   fcs_row_t    rows [8];

   fcs_scanner #(.AW(16)) dut (
      .clk(clk), .rst_b(rst_b), .clkEn(clkEn), .ctrlWrCpu(ctrlWrCpu),
      .ctrlWrDbg(ctrlWrDbg), .ctrlWdata(ctrlWdata), .cfgWrCpu(cfgWrCpu),
      .cfgWrDbg(cfgWrDbg), .cfgWdata(cfgWdata), .statWrDbg(statWrDbg),
      .statWdata(statWdata), .dbgAccess(dbgAccess),
      .dbgRelease(dbgRelease), .dbgMirrorRd(dbgMirrorRd),
      .cpuSleep(cpuSleep), .initPhase(initPhase),
      .initScanEn(initScanEn), .initSrc(initSrc), .bootLast(bootLast),
      .appLast(appLast), .flashLast(flashLast), .flashData(flashData),
      .flashRd(flashRd), .flashAddr(flashAddr), .cpuStall(cpuStall),
      .enableOut(enableOut), .nmiEnOut(nmiEnOut), .modeOut(modeOut),
      .srcOut(srcOut), .busyOut(busyOut), .okOut(okOut),
      .nmiReq(nmiReq), .dbgBusy(dbgBusy), .dbgOk(dbgOk),
      .cpuInitHold(cpuInitHold));

   fcs_flash_model #(.AW(16)) flash (
      .clk(clk), .flashRd(flashRd), .flashAddr(flashAddr),
      .flashData(flashData));

   //------------------------------------------------------------
   // Clock, fetch counter and hang guard
   //------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk) begin
      if (flashRd === 1'b1) fetches++;
      cyc++;
      if (cyc == LIMIT) begin
         err_total++;
         test_done();
      end
   end

   //------------------------------------------------------------
   // Helpers
   //------------------------------------------------------------
   task automatic test_done();
      $display("Checks %0d, errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic tick(input int k);
      repeat (k) begin
         @(posedge clk);
         #1;
      end
   endtask

   // Reference CRC, MSB first, preset all ones
   function automatic logic [15:0] crcTo(input int last);
      logic [15:0] c;
      c = 16'hFFFF;
      for (int i = 0; i <= last; i++) begin
         c = c ^ {flash.mem[i], 8'h00};
         for (int b = 0; b < 8; b++) c = c[15] ? (c << 1) ^ 16'h1021 : c << 1;
      end
      return c;
   endfunction

   function automatic int lastOf(input logic [1:0] src);
      return (src == SRC_FLASH) ? 63 : (src == SRC_APPBOOT) ? 31 : 15;
   endfunction

   task automatic seal(input int last);
      logic [15:0] c;
      c = crcTo(last - 2);
      flash.mem[last-1] = c[15:8];
      flash.mem[last] = c[7:0];
   endtask

   task automatic ctl(input logic dbg, input logic [2:0] d);
      ctrlWrCpu = !dbg;
      ctrlWrDbg = dbg;
      ctrlWdata = d;
      tick(1);
      ctrlWrCpu = 1'b0;
      ctrlWrDbg = 1'b0;
   endtask

   task automatic cfg(input logic dbg, input logic [3:0] d);
      cfgWrCpu = !dbg;
      cfgWrDbg = dbg;
      cfgWdata = d;
      tick(1);
      cfgWrCpu = 1'b0;
      cfgWrDbg = 1'b0;
   endtask

   task automatic stat(input logic [1:0] d);
      statWrDbg = 1'b1;
      statWdata = d;
      tick(1);
      statWrDbg = 1'b0;
   endtask

   // One-cycle pulse on {mirror read, release, access}
   task automatic dbgPulse(input logic [2:0] k);
      {dbgMirrorRd, dbgRelease, dbgAccess} = k;
      tick(1);
      {dbgMirrorRd, dbgRelease, dbgAccess} = 3'h0;
   endtask

   task automatic waitIdle();
      n = 0;
      while (busyOut !== 1'b0 && n < 2000) begin
         tick(1);
         n++;
      end
      `CHK(busyOut, 1'b0)
   endtask

   // Start a scan and follow the first two fetches
   task automatic start(input logic dbg, input logic [1:0] src);
      cfg(dbg, {2'h0, src});
      fetches = 0;
      ctl(dbg, 3'h1);
      `CHK(busyOut, 1'b1)
      tick(2);
      `CHK(cpuStall, 1'b1)
      tick(1);
      `CHK({flashRd, flashAddr}, {1'b1, 16'h0000})
      tick(3);
      `CHK({flashRd, flashAddr}, {1'b1, 16'h0002})
   endtask

   task automatic finish(input int last, input logic expOk);
      waitIdle();
      `CHK(fetches, (last + 1) / 2)
      `CHK(okOut, expOk)
   endtask

   //------------------------------------------------------------
   // Main sequence
   //------------------------------------------------------------
   initial begin
      {rst_b, ctrlWrCpu, ctrlWrDbg, cfgWrCpu, cfgWrDbg, statWrDbg} = '0;
      {dbgAccess, dbgRelease, dbgMirrorRd, cpuSleep, initPhase} = '0;
      {ctrlWdata, cfgWdata, statWdata, initSrc, initScanEn} = '0;
      clkEn = 1'b1;
      bootLast = 16'h000F;
      appLast = 16'h001F;
      flashLast = 16'h003F;
      err_total = 0;
      checks = 0;
      cyc = 0;
      for (int i = 0; i < 64; i++) flash.mem[i] = 8'(i * 7 + 3);
      seal(15);
      seal(31);
      seal(63);
      rows = '{'{2'h0, 8'hFF, 1'b1}, '{2'h1, 8'hFF, 1'b1},
               '{2'h2, 8'hFF, 1'b1}, '{2'h3, 8'hFF, 1'b1},
               '{2'h0, 8'h28, 1'b0}, '{2'h1, 8'h28, 1'b1},
               '{2'h2, 8'h28, 1'b1}, '{2'h2, 8'h03, 1'b0}};
      tick(2);
      rst_b = 1'b1;
      `CHK({busyOut, okOut, nmiReq, enableOut, cpuStall}, 5'h00)
      // Scan during reset initialisation
      {initScanEn, initSrc, initPhase} = {1'b1, SRC_BOOT, 1'b1};
      tick(1);
      `CHK({enableOut, modeOut, srcOut}, {1'b1, MODE_INIT, SRC_BOOT})
      `CHK(cpuInitHold, 1'b1)
      waitIdle();
      `CHK({okOut, cpuInitHold}, 2'b10)
      initPhase = 1'b0;
      // Section table, CPU and debugger writes alternating
      foreach (rows[i]) begin
         if (rows[i].bad != 8'hFF) flash.mem[rows[i].bad] ^= 8'h5A;
         start(i[0], rows[i].src);
         finish(lastOf(rows[i].src), rows[i].expOk);
         if (rows[i].bad != 8'hFF) flash.mem[rows[i].bad] ^= 8'h5A;
      end
      stat(2'b10);
      `CHK(okOut, 1'b1)
      // Writes while busy, then sleep mid-scan
      start(1'b0, SRC_BOOT);
      cfg(1'b0, 4'h0);
      `CHK(srcOut, SRC_BOOT)
      ctl(1'b0, 3'h2);
      `CHK(nmiEnOut, 1'b0)
      cpuSleep = 1'b1;
      tick(2);
      n = fetches;
      tick(10);
      `CHK({fetches, busyOut}, {n, 1'b1})
      // Clock enable low freezes the scan even after wake
      clkEn = 1'b0;
      cpuSleep = 1'b0;
      tick(10);
      `CHK({fetches, busyOut, cpuStall}, {n, 1'b1, 1'b1})
      clkEn = 1'b1;
      finish(15, 1'b1);
      // Debugger hold, then restart from byte 0
      start(1'b0, SRC_FLASH);
      dbgPulse(3'h1);
      tick(2);
      n = fetches;
      tick(12);
      `CHK({fetches, busyOut}, {n, 1'b1})
      fetches = 0;
      dbgPulse(3'h2);
      n = 0;
      while (flashRd !== 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      `CHK(flashAddr, 16'h0000)
      finish(63, 1'b1);
      // Abandon under hold
      start(1'b0, SRC_FLASH);
      dbgPulse(3'h1);
      stat(2'b10);
      `CHK(busyOut, 1'b0)
      n = fetches;
      dbgPulse(3'h2);
      tick(12);
      `CHK({fetches, busyOut}, {n, 1'b0})
      // Single scan armed by the debugger, run on mirror read
      dbgPulse(3'h1);
      stat(2'b01);
      tick(1);
      `CHK({busyOut, dbgBusy}, 2'b11)
      n = fetches;
      tick(10);
      `CHK(fetches, n)
      fetches = 0;
      dbgPulse(3'h4);
      finish(63, 1'b1);
      tick(1);
      `CHK({dbgBusy, dbgOk}, 2'b01)
      // Failing scan with the trigger enabled
      ctl(1'b0, 3'h2);
      `CHK(nmiEnOut, 1'b1)
      flash.mem[3] ^= 8'h5A;
      start(1'b0, SRC_BOOT);
      waitIdle();
      `CHK({okOut, nmiReq}, 2'b01)
      ctl(1'b0, 3'h4);
      cfg(1'b0, 4'h1);
      `CHK({enableOut, srcOut}, {1'b1, SRC_BOOT})
      tick(20);
      `CHK(nmiReq, 1'b1)
      flash.mem[3] ^= 8'h5A;
      rst_b = 1'b0;
      tick(2);
      rst_b = 1'b1;
      `CHK(nmiReq, 1'b0)
      // Debugger clears the pass flag
      ctl(1'b1, 3'h2);
      stat(2'b00);
      `CHK({okOut, nmiReq}, 2'b01)
      test_done();
   end
endmodule
